// ==== rtl/ccc_pkg.sv ====
package ccc_pkg;
	// Phase encoding of one coil chopper.
	typedef enum logic [2:0] {
		CCC_IDLE  = 3'b000,
		CCC_ON    = 3'b001,
		CCC_SLOW1 = 3'b010,
		CCC_FAST  = 3'b011,
		CCC_SLOW2 = 3'b100
	} ccc_phase_t;

	localparam int CCC_TW = 12;
	// Off time in device clock cycles per select code.
	localparam logic [CCC_TW-1:0] CCC_TOFF_LOW  = 12'h08c;
	localparam logic [CCC_TW-1:0] CCC_TOFF_HIGH = 12'h118;
	// Blanking interval in device clock cycles.
	localparam logic [CCC_TW-1:0] CCC_TBLANK    = 12'h018;
	// Fast decay timer base and per-hysteresis-step increment.
	localparam logic [CCC_TW-1:0] CCC_TFAST_BASE = 12'h020;
	localparam logic [CCC_TW-1:0] CCC_TFAST_STEP = 12'h010;
	localparam logic [CCC_TW-1:0] CCC_TIMER_ZERO = 12'h000;
	localparam logic [CCC_TW-1:0] CCC_TIMER_ONE  = 12'h001;
	// Minimum on/fast length above blanking.
	localparam logic [CCC_TW-1:0] CCC_TMIN_MARGIN = 12'h001;
	localparam int CCC_HW = 2;
endpackage

// ==== rtl/ccc_coil.sv ====
`timescale 1ns/1ps
module ccc_coil (
	input  wire logic                       i_clk_sys,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_ce,
	input  wire logic                       i_enable,
	input  wire logic                       i_cmp_reached,
	input  wire logic [ccc_pkg::CCC_TW-1:0] i_toff,
	input  wire logic [ccc_pkg::CCC_TW-1:0] i_tfast,
	output logic                            o_drive_on,
	output logic                            o_drive_fast,
	output logic                            o_blank,
	output ccc_pkg::ccc_phase_t             o_phase
);
	ccc_pkg::ccc_phase_t          phase, next_phase;
	logic [ccc_pkg::CCC_TW-1:0]   tmr, next_tmr;
	logic [ccc_pkg::CCC_TW-1:0]   blk, next_blk;
	logic                         cmp_ok;
	logic                         min_done;

	// Comparator counts only once blanking has run out.
	assign cmp_ok   = i_cmp_reached && (blk == ccc_pkg::CCC_TIMER_ZERO); // RL6
	// On and fast phases cannot end before blanking plus a margin elapsed.
	assign min_done = (blk == ccc_pkg::CCC_TIMER_ZERO); // RL7

	always_comb begin
		next_phase = phase;
		next_tmr   = tmr;
		next_blk   = (blk != ccc_pkg::CCC_TIMER_ZERO) ?
			blk - ccc_pkg::CCC_TIMER_ONE : blk; // RL11
		if (tmr != ccc_pkg::CCC_TIMER_ZERO)
			next_tmr = tmr - ccc_pkg::CCC_TIMER_ONE; // RL11
		if (!i_enable) begin
			next_phase = ccc_pkg::CCC_IDLE;
			next_tmr   = ccc_pkg::CCC_TIMER_ZERO;
			next_blk   = ccc_pkg::CCC_TIMER_ZERO;
		end else begin
			case (phase)
			ccc_pkg::CCC_IDLE: begin
				next_phase = ccc_pkg::CCC_ON;
				next_blk   = ccc_pkg::CCC_TBLANK + ccc_pkg::CCC_TMIN_MARGIN;
			end
			ccc_pkg::CCC_ON: begin
				if (min_done && cmp_ok) begin // RL4
					next_phase = ccc_pkg::CCC_SLOW1; // RL1
					next_tmr   = i_toff; // RL8
				end
			end
			ccc_pkg::CCC_SLOW1: begin
				if (tmr == ccc_pkg::CCC_TIMER_ONE) begin // RL3
					next_phase = ccc_pkg::CCC_FAST; // RL1
					next_tmr   = i_tfast; // RL9
					next_blk   = ccc_pkg::CCC_TBLANK +
						ccc_pkg::CCC_TMIN_MARGIN; // RL6
				end
			end
			ccc_pkg::CCC_FAST: begin
				if (min_done && (cmp_ok ||
					tmr <= ccc_pkg::CCC_TIMER_ONE)) begin // RL5
					next_phase = ccc_pkg::CCC_SLOW2; // RL1
					next_tmr   = i_toff; // RL8
				end
			end
			ccc_pkg::CCC_SLOW2: begin
				if (tmr == ccc_pkg::CCC_TIMER_ONE) begin // RL3
					next_phase = ccc_pkg::CCC_ON; // RL1
					next_blk   = ccc_pkg::CCC_TBLANK +
						ccc_pkg::CCC_TMIN_MARGIN; // RL6
				end
			end
			default: begin
				next_phase = ccc_pkg::CCC_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			phase        <= ccc_pkg::CCC_IDLE;
			tmr          <= ccc_pkg::CCC_TIMER_ZERO;
			blk          <= ccc_pkg::CCC_TIMER_ZERO;
			o_drive_on   <= 1'b0;
			o_drive_fast <= 1'b0;
			o_blank      <= 1'b0;
			o_phase      <= ccc_pkg::CCC_IDLE;
		end else if (i_ce) begin
			phase        <= next_phase;
			tmr          <= next_tmr;
			blk          <= next_blk;
			o_drive_on   <= (next_phase == ccc_pkg::CCC_ON);
			o_drive_fast <= (next_phase == ccc_pkg::CCC_FAST);
			o_blank      <= (next_blk != ccc_pkg::CCC_TIMER_ZERO);
			o_phase      <= next_phase;
		end
	end
endmodule // ccc_coil

// ==== rtl/ccc_chopper.sv ====
`timescale 1ns/1ps
// Functional notes
// [RL1] Phases run on, slow decay, fast decay, slow decay, then on again.
// [RL2] Two coil choppers run independently with own state and comparator.
// [RL3] Slow decay phases end only on timer expiry.
// [RL4] On phase ends when the comparator reports target current reached.
// [RL5] Fast decay ends on comparator or fast timer, whichever first.
// [RL6] Comparator is masked for a blanking interval after each switch.
// [RL7] On and fast decay phases last longer than the blanking interval.
// [RL8] Slow decay length comes from off-time setting, twice per cycle.
// [RL9] Fast decay length is derived from hysteresis setting automatically.
// [RL10] Hysteresis select grounded gives the lowest hysteresis setting.
// [RL11] Timers count device clocks, loaded at phase entry, expire at end.
module ccc_chopper (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_ce,
	input  wire logic        i_enable,
	input  wire logic        i_cmp_a,
	input  wire logic        i_cmp_b,
	input  wire logic        i_off_time_select_pin,
	input  wire logic [1:0]  i_hysteresis_select_pin,
	output logic             o_a_drive_on,
	output logic             o_a_drive_fast,
	output logic             o_a_blank,
	output logic             o_b_drive_on,
	output logic             o_b_drive_fast,
	output logic             o_b_blank
);
	// Pins are asynchronous: two stages before use.
	logic [3:0]                 sync1, sync2, next_sync1, next_sync2;
	logic [1:0]                 cmp_s1, cmp_s2, next_cmp_s1, next_cmp_s2;
	logic [ccc_pkg::CCC_TW-1:0] toff, next_toff;
	logic [ccc_pkg::CCC_TW-1:0] tfast, next_tfast;

	function automatic logic [ccc_pkg::CCC_TW-1:0] fast_len(
		input logic [ccc_pkg::CCC_HW-1:0] h);
		// Code zero is the lowest ripple, hence the shortest fast decay.
		fast_len = ccc_pkg::CCC_TFAST_BASE +
			ccc_pkg::CCC_TFAST_STEP * {10'h000, h}; // RL10
	endfunction

	always_comb begin
		next_sync1  = {i_enable, i_off_time_select_pin,
			i_hysteresis_select_pin};
		next_sync2  = sync1;
		next_cmp_s1 = {i_cmp_b, i_cmp_a};
		next_cmp_s2 = cmp_s1;
		next_toff   = sync2[2] ? ccc_pkg::CCC_TOFF_HIGH :
			ccc_pkg::CCC_TOFF_LOW; // RL8
		next_tfast  = fast_len(sync2[1:0]); // RL9
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync1  <= 4'h0;
			sync2  <= 4'h0;
			cmp_s1 <= 2'h0;
			cmp_s2 <= 2'h0;
			toff   <= ccc_pkg::CCC_TOFF_LOW;
			tfast  <= ccc_pkg::CCC_TFAST_BASE;
		end else if (i_ce) begin
			sync1  <= next_sync1;
			sync2  <= next_sync2;
			cmp_s1 <= next_cmp_s1;
			cmp_s2 <= next_cmp_s2;
			toff   <= next_toff;
			tfast  <= next_tfast;
		end
	end

	// One independent instance per coil.
	ccc_coil u_coil_a ( // RL2
		.i_clk_sys     (i_clk_sys),
		.i_rst_n       (i_rst_n),
		.i_ce          (i_ce),
		.i_enable      (sync2[3]),
		.i_cmp_reached (cmp_s2[0]),
		.i_toff        (toff),
		.i_tfast       (tfast),
		.o_drive_on    (o_a_drive_on),
		.o_drive_fast  (o_a_drive_fast),
		.o_blank       (o_a_blank),
		.o_phase       ()
	);

	ccc_coil u_coil_b ( // RL2
		.i_clk_sys     (i_clk_sys),
		.i_rst_n       (i_rst_n),
		.i_ce          (i_ce),
		.i_enable      (sync2[3]),
		.i_cmp_reached (cmp_s2[1]),
		.i_toff        (toff),
		.i_tfast       (tfast),
		.o_drive_on    (o_b_drive_on),
		.o_drive_fast  (o_b_drive_fast),
		.o_blank       (o_b_blank),
		.o_phase       ()
	);
endmodule // ccc_chopper

// ==== verif/ccc_coil_model.sv ====
`timescale 1ns/1ps
module ccc_coil_model (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic        i_drive_on,
	input  wire logic        i_drive_fast,
	input  wire logic [11:0] i_on_dly,
	input  wire logic [11:0] i_fast_dly,
	output logic             o_cmp
);
	logic [11:0] cnt;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n)
			cnt <= 12'h000;
		else
			cnt <= (i_drive_on || i_drive_fast) ? cnt + 12'h001 : 12'h000;
	end
	// No current passes the sense resistor in slow decay, so it reads low.
	assign o_cmp = i_drive_on ? (cnt >= i_on_dly)
		: (i_drive_fast && cnt >= i_fast_dly);
endmodule // ccc_coil_model

// ==== verif/ccc_chopper_assertions.sv ====
`timescale 1ns/1ps
module ccc_chk (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic i_enable,
	input wire logic i_cmp_a,
	input wire logic i_cmp_b,
	input wire logic i_off_time_select_pin,
	input wire logic o_a_drive_on,
	input wire logic o_a_drive_fast,
	input wire logic o_a_blank,
	input wire logic o_b_drive_on,
	input wire logic o_b_drive_fast,
	input wire logic o_b_blank
);
	default clocking @(posedge i_clk_sys); endclocking
	// Settings change only while disabled, and a held clock enable stretches
	// every phase by the frozen cycles, so checks pause in both cases.
	default disable iff (!i_rst_n || !i_enable || !i_ce);
	chk_phase_excl: assert property (!(o_a_drive_on && o_a_drive_fast))
		else $error("on and fast overlap");
	chk_slow1_len: assert property ($fell(o_a_drive_on) &&
		!i_off_time_select_pin |-> ##139 !o_a_drive_fast ##1 o_a_drive_fast)
		else $error("first slow decay length");
	chk_slow2_len: assert property ($fell(o_a_drive_fast) &&
		!i_off_time_select_pin |-> ##139 !o_a_drive_on ##1 o_a_drive_on)
		else $error("second slow decay length");
	chk_blank_len: assert property ($rose(o_a_blank) |->
		##24 o_a_blank ##1 !o_a_blank) else $error("blank length");
	chk_blank_sw: assert property ($rose(o_a_drive_on) ||
		$rose(o_a_drive_fast) |-> o_a_blank) else $error("no blank");
	chk_on_cmp: assert property ($fell(o_a_drive_on) |->
		$past(i_cmp_a, 3) && !$past(o_a_blank)) else $error("on end");
	chk_fast_win: assert property ($rose(o_a_drive_fast) |->
		##[26:80] $fell(o_a_drive_fast)) else $error("fast length");
	chk_coil_b: assert property ($fell(o_b_drive_on) |->
		$past(i_cmp_b, 3)) else $error("coil b on end");
	chk_b_excl: assert property (
		!(o_b_drive_on && o_b_drive_fast)) else $error("coil b overlap");
	chk_b_blank_sw: assert property ($rose(o_b_drive_on) ||
		$rose(o_b_drive_fast) |-> o_b_blank) else $error("coil b no blank");
	chk_b_blank_len: assert property ($rose(o_b_blank) |->
		##24 o_b_blank ##1 !o_b_blank) else $error("coil b blank length");
	cover property ($fell(o_a_drive_fast));
	cover property ($fell(o_b_drive_on));
	cover property ($fell(o_a_drive_on) && i_off_time_select_pin);
endmodule // ccc_chk
bind ccc_chopper ccc_chk chk_u (.*);

// ==== verif/coil_current_chopper_control_tb_top.sv ====
`timescale 1ns/1ps
module coil_current_chopper_control_tb_top;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        en = 1'h0;
	logic        ce = 1'h1;
	logic        sel = 1'h0;
	logic [1:0]  hys = 2'h0;
	logic [11:0] fa = 12'h005;
	logic        cmp_a, cmp_b, a_on, a_fast, b_on, b_fast;
	int          n_errors = 0;
	int          tests_run = 0;
	int          n;
	always #2.5 clk = ~clk;
	ccc_chopper dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(ce),
		.i_enable(en), .i_cmp_a(cmp_a), .i_cmp_b(cmp_b),
		.i_off_time_select_pin(sel), .i_hysteresis_select_pin(hys),
		.o_a_drive_on(a_on), .o_a_drive_fast(a_fast), .o_a_blank(),
		.o_b_drive_on(b_on), .o_b_drive_fast(b_fast), .o_b_blank());
	ccc_coil_model pa_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_drive_on(a_on),
		.i_drive_fast(a_fast), .i_on_dly(12'h028), .i_fast_dly(fa),
		.o_cmp(cmp_a));
	ccc_coil_model pb_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_drive_on(b_on),
		.i_drive_fast(b_fast), .i_on_dly(12'h05a), .i_fast_dly(12'h005),
		.o_cmp(cmp_b));
	function automatic logic pick(int s);
		case (s)
			0: return a_on;
			1: return a_fast;
			2: return !(a_on || a_fast);
			default: return b_on;
		endcase
	endfunction
	// Skip any phase already under way so only whole phases are timed.
	task automatic meas(input int s);
		n = 0;
		@(negedge clk);
		while (pick(s)) @(negedge clk);
		while (!pick(s)) @(negedge clk);
		while (pick(s)) begin
			n++;
			@(negedge clk);
		end
	endtask
	task automatic check(input string nm, input int lo, input int hi);
		tests_run++;
		if (n < lo || n > hi) begin
			n_errors++;
			$display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, n);
		end
	endtask
	task automatic cfg(input logic s, input logic [1:0] h);
		@(posedge clk);
		en <= 1'h0;
		repeat (8) @(posedge clk);
		sel <= s;
		hys <= h;
		en <= 1'h1;
	endtask
	task automatic results();
		$display("Checks %0d, errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic test_on_fast();
		cfg(1'h0, 2'h0);
		meas(0);
		check("on_a", 41, 46);
		meas(3);
		check("on_b", 91, 96);
		meas(1);
		check("fast_cmp", 26, 30);
		$display("on and fast decay test done");
	endtask
	task automatic test_fast_timer();
		for (int h = 0; h < 4; h++) begin
			cfg(1'h0, h[1:0]);
			fa <= 12'hfff;
			meas(1);
			check("fast_timer", 32 + 16 * h, 32 + 16 * h);
		end
		$display("fast timer test done");
	endtask
	task automatic test_slow();
		cfg(1'h1, 2'h0);
		fa <= 12'h005;
		meas(2);
		check("slow_hi", 280, 280);
		cfg(1'h0, 2'h0);
		meas(2);
		check("slow_lo", 140, 140);
		$display("slow decay test done");
	endtask
	// Ten frozen edges inside the first slow decay must stretch it by ten.
	task automatic test_ce_hold();
		@(negedge clk);
		while (!a_on) @(negedge clk);
		while (a_on) @(negedge clk);
		n = 1;
		@(posedge clk);
		ce <= 1'h0;
		repeat (10) @(posedge clk);
		ce <= 1'h1;
		n += 10;
		@(negedge clk);
		while (!a_fast) begin
			n++;
			@(negedge clk);
		end
		check("ce_hold", 150, 150);
		$display("clock enable test done");
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		test_on_fast();
		test_fast_timer();
		test_slow();
		test_ce_hold();
		results();
	end
	initial begin
		#100000;
		n_errors++;
		results();
	end
endmodule // coil_current_chopper_control_tb_top
